// file: hw/mcmm_core_regs.sv
// Purpose: Core working registers and memory map of the 8-bit core.
// Assumes: Core sequencer issues one operation per clock.
// Notes: Flash stays read only unless programming mode is asserted.
`timescale 1ns/1ns
module mcmm_core_regs
   import mcmm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] op_i,
   input wire logic [7:0] op_data_i,
   input wire logic [15:0] op_wide_i,
   input wire logic dir_valid_i,
   input wire logic dir_we_i,
   input wire logic dir_indirect_i,
   input wire logic [7:0] dir_addr_i,
   input wire logic [7:0] dir_wdata_i,
   input wire logic xm_valid_i,
   input wire logic xm_we_i,
   input wire logic xm_code_i,
   input wire logic [15:0] xm_addr_i,
   input wire logic [7:0] xm_wdata_i,
   input wire logic [7:0] page_i,
   input wire logic main_in_code_i,
   input wire logic sec_in_code_i,
   input wire logic ddc_en_i,
   input wire logic [15:0] psd_base_i,
   input wire logic flash_prog_i,
   output logic [7:0] accumulator_o,
   output logic [7:0] multiply_divide_operand_o,
   output logic [7:0] stack_pointer_o,
   output logic [7:0] dir_rdata_o,
   output logic [7:0] xm_rdata_o,
   output logic [2:0] xm_tgt_o,
   output logic flash_wr_o,
   output logic [17:0] flash_addr_o,
   output logic [7:0] flash_wdata_o,
   output logic xm_wr_dropped_o
);
   logic [7:0] accumulator;
   logic [7:0] multiply_divide_operand;
   logic [7:0] stack_pointer;
   logic [7:0] next_sp;
   logic ram_we;
   logic [7:0] ram_waddr;
   logic [7:0] ram_wdata;
   logic [7:0] ram_raddr;
   logic [7:0] ram_rdata;
   logic sfr_sel_q;
   logic [7:0] sfr_q;
   mcmm_st_t st;
   mcmm_tgt_t tgt;
   logic [17:0] xoff;
   logic [7:0] ddc_mem [0:255];
   logic [7:0] psd_mem [0:32767];
   logic [15:0] prod;

   function automatic logic is_sfr(input logic [7:0] a,
                                   input logic ind);
      is_sfr = a[7] && !ind;
   endfunction

   function automatic logic [7:0] sp_inc(input logic [7:0] s);
      sp_inc = s + 8'h01;
   endfunction

   assign prod = accumulator * multiply_divide_operand;

   // Pre-increment push: the byte lands at the incremented pointer.
   always_comb begin
      next_sp = stack_pointer;
      if (op_i == MCMM_OP_PUSH) begin
         next_sp = sp_inc(stack_pointer);
      end else if (op_i == MCMM_OP_POP) begin
         next_sp = stack_pointer - 8'h01;
      end else if (dir_valid_i && dir_we_i &&
                   is_sfr(dir_addr_i, dir_indirect_i) &&
                   dir_addr_i == `MCMM_SFR_SP) begin
         next_sp = dir_wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         stack_pointer <= `MCMM_SP_RESET;
      end else begin
         stack_pointer <= next_sp;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         st <= MCMM_ST_IDLE;
      end else begin
         unique case (op_i)
            MCMM_OP_PUSH: st <= MCMM_ST_PUSH;
            MCMM_OP_POP: st <= MCMM_ST_POP;
            default: st <= MCMM_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         accumulator <= `MCMM_ACC_RESET;
         multiply_divide_operand <= `MCMM_B_RESET;
      end else if (op_i == MCMM_OP_MUL) begin
         accumulator <= prod[7:0];
         multiply_divide_operand <= prod[15:8];
      end else if (op_i == MCMM_OP_DIV) begin
         if (multiply_divide_operand != 8'h00) begin
            accumulator <= accumulator / multiply_divide_operand;
            multiply_divide_operand <=
               accumulator % multiply_divide_operand;
         end
      end else if (op_i == MCMM_OP_LD16) begin
         {multiply_divide_operand, accumulator} <= op_wide_i;
      end else if (dir_valid_i && dir_we_i &&
                   is_sfr(dir_addr_i, dir_indirect_i)) begin
         if (dir_addr_i == `MCMM_SFR_ACC) begin
            accumulator <= dir_wdata_i;
         end
         if (dir_addr_i == `MCMM_SFR_B) begin
            multiply_divide_operand <= dir_wdata_i;
         end
      end
   end

   // Indirect accesses to the upper half reach RAM, never the registers.
   always_comb begin
      ram_we = 1'b0;
      ram_waddr = dir_addr_i;
      ram_wdata = dir_wdata_i;
      ram_raddr = dir_addr_i;
      if (op_i == MCMM_OP_PUSH) begin
         ram_we = 1'b1;
         ram_waddr = next_sp;
         ram_wdata = op_data_i;
      end else if (op_i == MCMM_OP_POP) begin
         ram_raddr = stack_pointer;
      end else if (dir_valid_i && dir_we_i &&
                   !is_sfr(dir_addr_i, dir_indirect_i)) begin
         ram_we = 1'b1;
      end
   end

   mcmm_iram u_iram (
      .sys_clk_i(sys_clk_i),
      .we_i(ram_we),
      .waddr_i(ram_waddr),
      .wdata_i(ram_wdata),
      .raddr_i(ram_raddr),
      .rdata_o(ram_rdata)
   );

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         sfr_sel_q <= 1'b0;
         sfr_q <= 8'h00;
      end else begin
         sfr_sel_q <= dir_valid_i && is_sfr(dir_addr_i, dir_indirect_i)
                      && op_i != MCMM_OP_POP;
         unique case (dir_addr_i)
            `MCMM_SFR_ACC: sfr_q <= accumulator;
            `MCMM_SFR_B: sfr_q <= multiply_divide_operand;
            `MCMM_SFR_SP: sfr_q <= stack_pointer;
            default: sfr_q <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         dir_rdata_o <= 8'h00;
      end else begin
         dir_rdata_o <= sfr_sel_q ? sfr_q : ram_rdata;
      end
   end

   mcmm_xdec u_xdec (
      .is_code_i(xm_code_i),
      .addr_i(xm_addr_i),
      .page_i(page_i),
      .main_in_code_i(main_in_code_i),
      .sec_in_code_i(sec_in_code_i),
      .ddc_en_i(ddc_en_i),
      .psd_base_i(psd_base_i),
      .tgt_o(tgt),
      .off_o(xoff)
   );

   always_ff @(posedge sys_clk_i) begin
      if (xm_valid_i && xm_we_i && !xm_code_i) begin
         if (tgt == MCMM_TGT_DDC) begin
            ddc_mem[xoff[7:0]] <= xm_wdata_i;
         end
         if (tgt == MCMM_TGT_PSD) begin
            psd_mem[xoff[14:0]] <= xm_wdata_i;
         end
      end
   end

   // Flash writes pass only while programming; otherwise they are dropped.
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         flash_wr_o <= 1'b0;
         xm_wr_dropped_o <= 1'b0;
         flash_addr_o <= 18'h0_0000;
         flash_wdata_o <= 8'h00;
         xm_tgt_o <= 3'h0;
         xm_rdata_o <= 8'h00;
      end else begin
         flash_wr_o <= xm_valid_i && xm_we_i && flash_prog_i &&
                       (tgt == MCMM_TGT_MAIN || tgt == MCMM_TGT_SEC);
         xm_wr_dropped_o <= xm_valid_i && xm_we_i && !flash_prog_i &&
                       (tgt == MCMM_TGT_MAIN ||
                        tgt == MCMM_TGT_SEC);
         flash_addr_o <= xoff;
         flash_wdata_o <= xm_wdata_i;
         xm_tgt_o <= xm_valid_i ? tgt : MCMM_TGT_NONE;
         xm_rdata_o <= (tgt == MCMM_TGT_DDC) ? ddc_mem[xoff[7:0]] :
                       (tgt == MCMM_TGT_PSD) ? psd_mem[xoff[14:0]] : 8'h00;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         accumulator_o <= `MCMM_ACC_RESET;
         multiply_divide_operand_o <= `MCMM_B_RESET;
         stack_pointer_o <= `MCMM_SP_RESET;
      end else begin
         accumulator_o <= accumulator;
         multiply_divide_operand_o <= multiply_divide_operand;
         stack_pointer_o <= stack_pointer;
      end
   end

   sp_reset_a: assert property (@(posedge sys_clk_i)
      $rose(resetn_i) |-> stack_pointer == 8'h07)
      else $error("stack pointer not 07h after reset");
   sp_push_inc_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      op_i == MCMM_OP_PUSH |=> stack_pointer == $past(stack_pointer) + 8'h01)
      else $error("push did not pre-increment");
   push_addr_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      op_i == MCMM_OP_PUSH |-> ram_waddr == stack_pointer + 8'h01)
      else $error("push byte not at incremented pointer");
   sp_wrap_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      (op_i == MCMM_OP_PUSH && stack_pointer == 8'hFF) |=>
      stack_pointer == 8'h00)
      else $error("stack pointer did not wrap");
   sfr_indirect_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      (dir_valid_i && dir_we_i && dir_indirect_i && op_i == MCMM_OP_NONE)
      |=> accumulator == $past(accumulator))
      else $error("indirect write reached a register");
   flash_ro_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      !$past(flash_prog_i) |-> !flash_wr_o)
      else $error("flash written outside programming");
   mul_pair_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      op_i == MCMM_OP_MUL |=>
      {multiply_divide_operand, accumulator} == $past(prod))
      else $error("multiply result wrong");
   // The output copy trails the register by one clock, hence two cycles.
   ld16_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      op_i == MCMM_OP_LD16 |-> ##2 accumulator_o == $past(op_wide_i[7:0], 2))
      else $error("16-bit load wrong");
   space_sep_a: assert property (@(posedge sys_clk_i)
      (xm_code_i && tgt != MCMM_TGT_NONE) |->
      tgt == MCMM_TGT_MAIN || tgt == MCMM_TGT_SEC)
      else $error("fetch decoded to data memory");
   push_c: cover property (@(posedge sys_clk_i) op_i == MCMM_OP_PUSH);
   wrap_c: cover property (@(posedge sys_clk_i)
      op_i == MCMM_OP_PUSH && stack_pointer == 8'hFF);
   drop_c: cover property (@(posedge sys_clk_i) xm_wr_dropped_o);
   pop_c: cover property (@(posedge sys_clk_i) st == MCMM_ST_POP);
endmodule

// file: include/mcmm_regs.svh
// Purpose: Constants for the core memory map and working registers.
// Assumes: Byte-wide data, 16-bit core addresses, 8-bit page register.
// Notes: Included by the package only; the design modules use its macros without an include.
`ifndef MCMM_REGS_SVH
`define MCMM_REGS_SVH
`define MCMM_SP_RESET 8'h07
`define MCMM_ACC_RESET 8'h00
`define MCMM_B_RESET 8'h00
`define MCMM_SFR_ACC 8'hE0
`define MCMM_SFR_B 8'hF0
`define MCMM_SFR_SP 8'h81
`define MCMM_SFR_BASE 8'h80
`define MCMM_DDC_BASE 16'hFF00
`define MCMM_MAIN_AW 18
`define MCMM_SEC_AW 15
`define MCMM_PSD_AW 15
`define MCMM_SEC_BASE 16'h8000
`endif

// file: include/mcmm_pkg.sv
`include "mcmm_regs.svh"
package mcmm_pkg;
   typedef enum logic [3:0] {
      MCMM_OP_NONE = 4'h0,
      MCMM_OP_PUSH = 4'h1,
      MCMM_OP_POP = 4'h2,
      MCMM_OP_MUL = 4'h3,
      MCMM_OP_DIV = 4'h4,
      MCMM_OP_LD16 = 4'h5
   } mcmm_op_t;
   typedef enum logic [2:0] {
      MCMM_ST_IDLE = 3'b001,
      MCMM_ST_PUSH = 3'b010,
      MCMM_ST_POP = 3'b100
   } mcmm_st_t;
   typedef enum logic [2:0] {
      MCMM_TGT_NONE = 3'h0,
      MCMM_TGT_MAIN = 3'h1,
      MCMM_TGT_SEC = 3'h2,
      MCMM_TGT_DDC = 3'h3,
      MCMM_TGT_PSD = 3'h4
   } mcmm_tgt_t;
endpackage

// file: hw/mcmm_iram.sv
// Purpose: Internal 256 byte data RAM, also holding the stack.
// Assumes: One write port and one registered read port.
// Notes: Read data follows the address by one clock.
`timescale 1ns/1ns
module mcmm_iram
   import mcmm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic we_i,
   input wire logic [7:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] raddr_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [0:255];
   always_ff @(posedge sys_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      rdata_o <= mem[raddr_i];
   end
endmodule

// file: hw/mcmm_xdec.sv
// Purpose: Decode of the external program and data spaces.
// Assumes: Flash mapping comes from the system module configuration.
// Notes: Pure combinational decode; the caller registers the result.
`timescale 1ns/1ns
module mcmm_xdec
   import mcmm_pkg::*;
(
   input wire logic is_code_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] page_i,
   input wire logic main_in_code_i,
   input wire logic sec_in_code_i,
   input wire logic ddc_en_i,
   input wire logic [15:0] psd_base_i,
   output mcmm_tgt_t tgt_o,
   output logic [17:0] off_o
);
   // Program and data spaces are decoded apart, so a fetch never aliases.
   always_comb begin
      tgt_o = MCMM_TGT_NONE;
      off_o = 18'h0_0000;
      if (!is_code_i && ddc_en_i && addr_i >= `MCMM_DDC_BASE) begin
         tgt_o = MCMM_TGT_DDC;
         off_o = {10'h000, addr_i[7:0]};
      end else if (addr_i >= `MCMM_SEC_BASE) begin
         if (sec_in_code_i == is_code_i) begin
            tgt_o = MCMM_TGT_SEC;
            off_o = {3'h0, addr_i[14:0]};
         end
      end else if (main_in_code_i == is_code_i) begin
         tgt_o = MCMM_TGT_MAIN;
         off_o = {page_i[3:0], addr_i[13:0]};
      end
      if (!is_code_i && tgt_o == MCMM_TGT_NONE &&
          addr_i >= psd_base_i && addr_i - psd_base_i < 16'h8000) begin
         tgt_o = MCMM_TGT_PSD;
         off_o = {3'h0, addr_i[14:0] - psd_base_i[14:0]};
      end
   end
endmodule

// file: tb/mcmm_flash_model.sv
// Purpose: Flash model on the far side of the flash write port.
// Assumes: One write is one flash_wr_o pulse lasting one clock.
// Notes: Keeps counts and the last write only; erase timing is not modelled.
`timescale 1ns/1ns
module mcmm_flash_model (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic wr_i,
   input wire logic [17:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic dropped_i,
   output logic [7:0] wr_count_o,
   output logic [7:0] drop_count_o,
   output logic [17:0] last_addr_o,
   output logic [7:0] last_data_o
);
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         wr_count_o <= 8'h00;
         drop_count_o <= 8'h00;
         last_addr_o <= 18'h0_0000;
         last_data_o <= 8'h00;
      end else begin
         if (wr_i) begin
            wr_count_o <= wr_count_o + 8'h01;
            last_addr_o <= addr_i;
            last_data_o <= wdata_i;
         end
         if (dropped_i) begin
            drop_count_o <= drop_count_o + 8'h01;
         end
      end
   end
endmodule

// file: tb/tb_mcu_core_memory_map_and_regs.sv
// Purpose: Self-checking bench for the core registers and memory map.
// Assumes: Requests are held until their answer has been sampled.
// Notes: Flash writes are seen through the flash model counts.
`timescale 1ns/1ns
module tb_mcu_core_memory_map_and_regs
   import mcmm_pkg::*;
;
   logic sys_clk_i = 1'b0, resetn_i = 1'b0;
   logic [3:0] op_i = 4'h0;
   logic [7:0] op_data_i = 8'h00, dir_addr_i = 8'h00, dir_wdata_i = 8'h00;
   logic [7:0] xm_wdata_i = 8'h00, page_i = 8'h00;
   logic [15:0] op_wide_i = 16'h0000, xm_addr_i = 16'h0000;
   logic [15:0] psd_base_i = 16'h4000;
   logic dir_valid_i = 1'b0, dir_we_i = 1'b0, dir_indirect_i = 1'b0;
   logic xm_valid_i = 1'b0, xm_we_i = 1'b0, xm_code_i = 1'b0;
   logic main_in_code_i = 1'b1, sec_in_code_i = 1'b1, ddc_en_i = 1'b1;
   logic flash_prog_i = 1'b0;
   logic [7:0] accumulator_o, multiply_divide_operand_o, stack_pointer_o;
   logic [7:0] dir_rdata_o, xm_rdata_o, flash_wdata_o;
   logic [2:0] xm_tgt_o;
   logic flash_wr_o, xm_wr_dropped_o;
   logic [17:0] flash_addr_o, last_addr;
   logic [7:0] wr_cnt, drop_cnt, last_data;
   int miscompares = 0, comparisons = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   mcmm_core_regs DUT (.*);
   mcmm_flash_model flash (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .wr_i(flash_wr_o), .addr_i(flash_addr_o), .wdata_i(flash_wdata_o),
      .dropped_i(xm_wr_dropped_o), .wr_count_o(wr_cnt),
      .drop_count_o(drop_cnt), .last_addr_o(last_addr),
      .last_data_o(last_data));
   task chk(input logic [17:0] seen, input logic [17:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Sampling 1 ns after the edge keeps clear of the edge's own updates.
   task cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task regs(input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
      chk(accumulator_o, a);
      chk(multiply_divide_operand_o, b);
      chk(stack_pointer_o, s);
   endtask
   task op(input logic [3:0] o, input logic [7:0] d, input logic [15:0] w);
      @(posedge sys_clk_i);
      op_i <= o;
      op_data_i <= d;
      op_wide_i <= w;
      @(posedge sys_clk_i);
      op_i <= MCMM_OP_NONE;
      cyc(2);
   endtask
   task dwr(input logic ind, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      dir_valid_i <= 1'b1;
      dir_we_i <= 1'b1;
      dir_indirect_i <= ind;
      dir_addr_i <= a;
      dir_wdata_i <= d;
      @(posedge sys_clk_i);
      dir_valid_i <= 1'b0;
      dir_we_i <= 1'b0;
      cyc(2);
   endtask
   task drd(input logic ind, input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk_i);
      dir_valid_i <= 1'b1;
      dir_we_i <= 1'b0;
      dir_indirect_i <= ind;
      dir_addr_i <= a;
      cyc(3);
      chk(dir_rdata_o, exp);
      @(posedge sys_clk_i);
      dir_valid_i <= 1'b0;
   endtask
   task xwr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      xm_valid_i <= 1'b1;
      xm_we_i <= 1'b1;
      xm_code_i <= 1'b0;
      xm_addr_i <= a;
      xm_wdata_i <= d;
      @(posedge sys_clk_i);
      xm_valid_i <= 1'b0;
      xm_we_i <= 1'b0;
      cyc(3);
   endtask
   task xrd(input logic c, input logic [15:0] a, input logic [7:0] exp,
      input logic [2:0] tgt);
      @(posedge sys_clk_i);
      xm_valid_i <= 1'b1;
      xm_we_i <= 1'b0;
      xm_code_i <= c;
      xm_addr_i <= a;
      cyc(2);
      chk(xm_rdata_o, exp);
      chk(xm_tgt_o, tgt);
      @(posedge sys_clk_i);
      xm_valid_i <= 1'b0;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      cyc(2);
      regs(8'h00, 8'h00, 8'h07);
      op(MCMM_OP_PUSH, 8'hA5, 16'h0000);
      regs(8'h00, 8'h00, 8'h08);
      drd(1'b0, 8'h08, 8'hA5);
      op(MCMM_OP_PUSH, 8'h5A, 16'h0000);
      drd(1'b0, 8'h09, 8'h5A);
      op(MCMM_OP_POP, 8'h00, 16'h0000);
      chk(stack_pointer_o, 8'h08);
      dwr(1'b0, 8'h81, 8'hFF);
      op(MCMM_OP_PUSH, 8'h3C, 16'h0000);
      chk(stack_pointer_o, 8'h00);
      drd(1'b0, 8'h00, 8'h3C);
      dwr(1'b0, 8'h81, 8'hBF);
      op(MCMM_OP_PUSH, 8'h77, 16'h0000);
      drd(1'b1, 8'hC0, 8'h77);
      drd(1'b0, 8'hC0, 8'h00);
      dwr(1'b0, 8'hE0, 8'h99);
      dwr(1'b1, 8'hE0, 8'h66);
      chk(accumulator_o, 8'h99);
      drd(1'b1, 8'hE0, 8'h66);
      drd(1'b0, 8'hE0, 8'h99);
      dwr(1'b0, 8'hF0, 8'hC5);
      drd(1'b0, 8'hF0, 8'hC5);
      op(MCMM_OP_LD16, 8'h00, 16'h1234);
      regs(8'h34, 8'h12, 8'hC0);
      op(MCMM_OP_MUL, 8'h00, 16'h0000);
      regs(8'hA8, 8'h03, 8'hC0);
      op(MCMM_OP_LD16, 8'h00, 16'h0764);
      op(MCMM_OP_DIV, 8'h00, 16'h0000);
      regs(8'h0E, 8'h02, 8'hC0);
      // A zero divisor must leave both operands untouched.
      op(MCMM_OP_LD16, 8'h00, 16'h0055);
      op(MCMM_OP_DIV, 8'h00, 16'h0000);
      regs(8'h55, 8'h00, 8'hC0);
      xwr(16'hFF10, 8'hC3);
      xrd(1'b0, 16'hFF10, 8'hC3, MCMM_TGT_DDC);
      xwr(16'h4321, 8'h5E);
      xrd(1'b0, 16'h4321, 8'h5E, MCMM_TGT_PSD);
      xrd(1'b1, 16'h4321, 8'h00, MCMM_TGT_MAIN);
      xrd(1'b1, 16'h9000, 8'h00, MCMM_TGT_SEC);
      @(posedge sys_clk_i);
      main_in_code_i <= 1'b0;
      page_i <= 8'h03;
      xrd(1'b0, 16'h1234, 8'h00, MCMM_TGT_MAIN);
      xwr(16'h1234, 8'hAB);
      chk(drop_cnt, 8'h01);
      chk(wr_cnt, 8'h00);
      @(posedge sys_clk_i);
      flash_prog_i <= 1'b1;
      xwr(16'h1234, 8'hAB);
      chk(wr_cnt, 8'h01);
      chk(last_addr, 18'h0_D234);
      chk(last_data, 8'hAB);
      chk(drop_cnt, 8'h01);
      test_done();
   end
   initial begin
      #400000;
      miscompares++;
      test_done();
   end
endmodule
